// file: logic/agu_pkg.sv
// Constants and types shared by the address generation and stack check unit
package agu_pkg;

  // ==========================================================================
  // Register file layout
  localparam logic [3:0] WORK_REG_ZERO = 4'h0;
  localparam logic [3:0] X_PREFETCH_PTR_A = 4'h8;
  localparam logic [3:0] X_PREFETCH_PTR_B = 4'h9;
  localparam logic [3:0] Y_PREFETCH_PTR_A = 4'hA;
  localparam logic [3:0] Y_PREFETCH_PTR_B = 4'hB;
  localparam logic [3:0] STACK_PTR_REG = 4'hF;
  localparam int NUM_WORK_REGS = 16;

  // ==========================================================================
  // Values after reset
  localparam logic [15:0] WORK_REG_RST = 16'h0000;
  localparam logic [15:0] STACK_PTR_RST = 16'h0800;

  // ==========================================================================
  // Stack and address figures
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] SFR_FLOOR = 16'h0800;
  localparam int FILE_ADDR_W = 13;
  localparam int LIT5_W = 5;
  localparam int LIT8_W = 8;
  localparam int INTDIS_LIT_W = 14;

  // ==========================================================================
  // Secure RAM segment windows, inclusive byte addresses
  localparam logic [15:0] BOOT_RAM_LO = 16'h0800;
  localparam logic [15:0] BOOT_RAM_HI = 16'h08FF;
  localparam logic [15:0] SEC_RAM_LO = 16'h0900;
  localparam logic [15:0] SEC_RAM_HI = 16'h09FF;

  // ==========================================================================
  // Instruction classes, addressing modes and stack operations
  typedef enum logic [2:0] {
    CL_FILE, CL_MCU, CL_MOVE, CL_DSP, CL_STACK, CL_BRANCH, CL_INTDIS
  } class_t;

  typedef enum logic [3:0] {
    M_DIRECT, M_IND, M_POST, M_PRE, M_INDEXED, M_LITOFF, M_LIT5, M_LIT8, M_LIT16
  } mode_t;

  typedef enum logic [1:0] {
    S_PUSH, S_PUSH_CALL_HI, S_PUSH_EXC_HI, S_POP
  } stk_t;

endpackage

// file: logic/addr_gen_stack_check.sv
// Effective address generation, software stack and secure RAM gating
// ============================================================================
// Notes on behaviour
// R1: Stack pointer always addresses first free word; stack grows upward.
// R2: Push writes at pointer then adds two; pop subtracts two then reads.
// R3: Call pushes of the upper PC word carry a clear upper byte.
// R4: Exception pushes put the status low byte in the upper PC word's top.
// R5: Limit register has no reset value; its bit 0 always reads zero.
// R6: Addresses from the stack pointer above the limit raise a stack trap.
// R7: Addresses from the stack pointer below 0x0800 raise a stack trap.
// R8: Software avoids a stack-pointer indirect read right after a limit write.
// R9: Boot secure RAM is reachable only from boot segment code when enabled; the gate checks ea only, not the Y address yEa.
// R10: Secure segment RAM is reachable only from secure segment code; the gate checks ea only, not the Y address yEa.
// R11: File register address is the 13-bit opcode field, first 8192 bytes.
// R12: File register results go to the file register or working register 0.
// R13: MCU operand 1 is register direct; operand 2 register, memory or 5-bit.
// R14: Register indirect uses the base pointer unchanged as address.
// R15: Post-modified indirect uses the pointer, then adds a constant to it.
// R16: Pre-modified indirect adds a signed constant first, then uses it.
// R17: Indexed adds offset register to base; literal offset adds a literal.
// R18: Move source and destination share one 4-bit offset register field.
// R19: Move class adds indexed, literal offset, 8-bit and 16-bit literals.
// R20: DSP prefetch uses registers 8 and 9 for X, 10 and 11 for Y.
// R21: DSP modes: indirect, post-modify by plus or minus 2, 4 or 6, indexed on second only.
// R22: Branch takes a 16-bit signed literal; interrupt disable a 14-bit one.
// R23: Stack trap request comes with the offending effective address.
`timescale 1ns/1ns
module addr_gen_stack_check (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Instruction request
  input wire logic opValid,
  input wire agu_pkg::class_t opClass,
  input wire agu_pkg::mode_t opMode,
  input wire agu_pkg::stk_t stackOp,
  input wire logic [3:0] baseSel,
  input wire logic [3:0] offsetSel,
  input wire logic [15:0] modConst,
  input wire logic [15:0] litField,
  input wire logic fileToWorkReg,
  // Y space pointer of a dual-operand DSP instruction
  input wire agu_pkg::mode_t yMode,
  input wire logic ySel,
  input wire logic [15:0] yModConst,
  // Stack push data
  input wire logic [15:0] pushData,
  input wire logic [7:0] statusLowByte,
  // Working register and limit writes
  input wire logic regWrEn,
  input wire logic [3:0] regWrSel,
  input wire logic [15:0] regWrData,
  input wire logic limWrEn,
  input wire logic [15:0] limWrData,
  // Executing code segment and protection enables
  input wire logic bootProtEn,
  input wire logic secProtEn,
  input wire logic execInBoot,
  input wire logic execInSecure,
  // Addresses and memory strobes
  output logic eaValid,
  output logic [15:0] ea,
  output logic yEaValid,
  output logic [15:0] yEa,
  output logic memRdEn,
  output logic memWrEn,
  output logic [15:0] memWrData,
  // Operands and status
  output logic [15:0] opAData,
  output logic [15:0] opBData,
  output logic [15:0] litOut,
  output logic resultToWorkReg,
  output logic accessDenied,
  output logic stackTrap,
  output logic modeErr,
  output logic [15:0] stackPtr,
  output logic [15:0] stackLimit
);

  // ==========================================================================
  // Decoding helpers
  function automatic logic [15:0] eaCalc(agu_pkg::mode_t m, logic [15:0] b,
                                         logic [15:0] o, logic [15:0] k);
    unique case (m)
      agu_pkg::M_PRE: eaCalc = b + k;
      agu_pkg::M_INDEXED: eaCalc = b + o;
      agu_pkg::M_LITOFF: eaCalc = b + k;
      default: eaCalc = b;
    endcase
  endfunction

  function automatic logic dspOk(agu_pkg::mode_t m, logic second, logic [15:0] k);
    unique case (m)
      agu_pkg::M_IND: dspOk = 1'b1;
      agu_pkg::M_INDEXED: dspOk = second;
      agu_pkg::M_POST: dspOk = (k == 16'h0002) || (k == 16'h0004) ||
                               (k == 16'h0006) || (k == 16'hFFFE) ||
                               (k == 16'hFFFC) || (k == 16'hFFFA);
      default: dspOk = 1'b0;
    endcase
  endfunction

  function automatic logic inWin(logic [15:0] a, logic [15:0] lo, logic [15:0] hi);
    inWin = (a >= lo) && (a <= hi);
  endfunction

  // ==========================================================================
  // State
  logic [15:0] workQ [agu_pkg::NUM_WORK_REGS];
  logic [15:0] limitQ;
  logic [15:0] sp;
  logic [15:0] baseVal;
  logic [15:0] offVal;
  logic [3:0] xIdx;
  logic [3:0] yIdx;

  assign sp = workQ[agu_pkg::STACK_PTR_REG];
  assign baseVal = workQ[baseSel];
  assign offVal = workQ[offsetSel];
  assign xIdx = baseSel[0] ? agu_pkg::X_PREFETCH_PTR_B : agu_pkg::X_PREFETCH_PTR_A;
  assign yIdx = ySel ? agu_pkg::Y_PREFETCH_PTR_B : agu_pkg::Y_PREFETCH_PTR_A;

  // ==========================================================================
  // Address formation
  logic eaGen;
  logic [15:0] eaD;
  logic [3:0] ptrIdx;
  logic wbEn;
  logic [15:0] wbVal;
  logic yGen;
  logic [15:0] yEaD;
  logic yWbEn;
  logic [15:0] yWbVal;
  logic rdD;
  logic wrD;
  logic [15:0] wrDataD;
  logic [15:0] opAD;
  logic [15:0] opBD;
  logic [15:0] litD;
  logic toWorkRegD;
  logic errD;
  logic [15:0] addK;

  assign addK = (opMode == agu_pkg::M_LITOFF) ? litField : modConst; // R17

  always_comb begin
    eaGen = 1'b0;
    eaD = 16'h0000;
    ptrIdx = baseSel;
    wbEn = 1'b0;
    wbVal = 16'h0000;
    yGen = 1'b0;
    yEaD = 16'h0000;
    yWbEn = 1'b0;
    yWbVal = 16'h0000;
    rdD = 1'b0;
    wrD = 1'b0;
    wrDataD = 16'h0000;
    opAD = 16'h0000;
    opBD = 16'h0000;
    litD = 16'h0000;
    toWorkRegD = 1'b0;
    errD = 1'b0;
    if (opValid) begin
      unique case (opClass)
        agu_pkg::CL_FILE: begin
          eaGen = 1'b1;
          eaD = {3'h0, litField[agu_pkg::FILE_ADDR_W-1:0]}; // R11
          rdD = 1'b1;
          opAD = workQ[agu_pkg::WORK_REG_ZERO]; // R12
          toWorkRegD = fileToWorkReg; // R12
          // Direct address with no pointer behind it, so no stack check
          ptrIdx = agu_pkg::WORK_REG_ZERO;
        end
        agu_pkg::CL_MCU, agu_pkg::CL_MOVE: begin
          opAD = offVal; // R13
          unique case (opMode)
            agu_pkg::M_DIRECT: opBD = baseVal; // R13
            agu_pkg::M_LIT5: opBD = {11'h000, litField[agu_pkg::LIT5_W-1:0]}; // R13
            agu_pkg::M_LIT8: begin
              opBD = {8'h00, litField[agu_pkg::LIT8_W-1:0]}; // R19
              errD = (opClass == agu_pkg::CL_MCU);
            end
            agu_pkg::M_LIT16: begin
              opBD = litField; // R19
              errD = (opClass == agu_pkg::CL_MCU);
            end
            default: begin
              // Index and literal offset exist only for the move class
              eaGen = 1'b1;
              eaD = eaCalc(opMode, baseVal, offVal, addK); // R14 R16 R17 R18
              rdD = 1'b1;
              errD = (opClass == agu_pkg::CL_MCU) && ((opMode == agu_pkg::M_INDEXED) ||
                     (opMode == agu_pkg::M_LITOFF)); // R19
              wbEn = (opMode == agu_pkg::M_POST) || (opMode == agu_pkg::M_PRE);
              wbVal = baseVal + modConst; // R15 R16
            end
          endcase
        end
        agu_pkg::CL_DSP: begin
          eaGen = 1'b1;
          ptrIdx = xIdx; // R20
          eaD = eaCalc(opMode, workQ[xIdx], offVal, modConst); // R21
          rdD = 1'b1;
          wbEn = (opMode == agu_pkg::M_POST);
          wbVal = workQ[xIdx] + modConst; // R21
          yGen = 1'b1;
          yEaD = eaCalc(yMode, workQ[yIdx], offVal, yModConst); // R20
          yWbEn = (yMode == agu_pkg::M_POST);
          yWbVal = workQ[yIdx] + yModConst;
          errD = !dspOk(opMode, baseSel[0], modConst) ||
                 !dspOk(yMode, ySel, yModConst); // R21
        end
        agu_pkg::CL_STACK: begin
          eaGen = 1'b1;
          ptrIdx = agu_pkg::STACK_PTR_REG;
          wbEn = 1'b1;
          if (stackOp == agu_pkg::S_POP) begin
            eaD = sp - agu_pkg::WORD_STEP; // R2
            wbVal = sp - agu_pkg::WORD_STEP; // R2
            rdD = 1'b1;
          end else begin
            eaD = sp; // R1 R2
            wbVal = sp + agu_pkg::WORD_STEP; // R2
            wrD = 1'b1;
            unique case (stackOp)
              agu_pkg::S_PUSH_CALL_HI: wrDataD = {8'h00, pushData[7:0]}; // R3
              agu_pkg::S_PUSH_EXC_HI: wrDataD = {statusLowByte, pushData[7:0]}; // R4
              default: wrDataD = pushData;
            endcase
          end
        end
        agu_pkg::CL_BRANCH: litD = litField; // R22
        agu_pkg::CL_INTDIS: litD = {2'h0, litField[agu_pkg::INTDIS_LIT_W-1:0]}; // R22
        // Unused class code
        default: errD = 1'b1;
      endcase
    end
  end

  // ==========================================================================
  // Checks on the formed address
  logic trapD;
  logic deniedD;

  // Floor is tested on the pointer too, so a pop that wraps past zero still traps
  assign trapD = eaGen && (ptrIdx == agu_pkg::STACK_PTR_REG) &&
                 ((eaD > limitQ) || (eaD < agu_pkg::SFR_FLOOR) ||
                  (sp < agu_pkg::SFR_FLOOR)); // R6 R7 R23

  assign deniedD = eaGen && (
    (bootProtEn && !execInBoot &&
     inWin(eaD, agu_pkg::BOOT_RAM_LO, agu_pkg::BOOT_RAM_HI)) || // R9
    (secProtEn && !execInSecure &&
     inWin(eaD, agu_pkg::SEC_RAM_LO, agu_pkg::SEC_RAM_HI))); // R10

  // ==========================================================================
  // Working registers: pointer updates win over a decode write to the same one
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int i = 0; i < agu_pkg::NUM_WORK_REGS; i++) begin
        workQ[i] <= agu_pkg::WORK_REG_RST;
      end
      workQ[agu_pkg::STACK_PTR_REG] <= agu_pkg::STACK_PTR_RST;
    end else begin
      if (regWrEn) begin
        workQ[regWrSel] <= regWrData;
      end
      if (wbEn) begin
        workQ[ptrIdx] <= wbVal; // R2 R15 R16
      end
      if (yWbEn) begin
        workQ[yIdx] <= yWbVal;
      end
    end
  end

  // Left without reset on purpose; software must load it before use
  always_ff @(posedge mclk) begin
    if (limWrEn) begin
      limitQ <= {limWrData[15:1], 1'b0}; // R5
    end
  end

  // ==========================================================================
  // Registered outputs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      eaValid <= 1'b0;
      ea <= 16'h0000;
      yEaValid <= 1'b0;
      yEa <= 16'h0000;
      memRdEn <= 1'b0;
      memWrEn <= 1'b0;
      memWrData <= 16'h0000;
      accessDenied <= 1'b0;
      stackTrap <= 1'b0;
    end else begin
      eaValid <= eaGen;
      ea <= eaD;
      yEaValid <= yGen;
      yEa <= yEaD;
      // A denied access never reaches memory
      memRdEn <= rdD && !deniedD; // R9 R10
      memWrEn <= wrD && !deniedD; // R9 R10
      memWrData <= wrDataD;
      accessDenied <= deniedD;
      stackTrap <= trapD; // R23
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      opAData <= 16'h0000;
      opBData <= 16'h0000;
      litOut <= 16'h0000;
      resultToWorkReg <= 1'b0;
      modeErr <= 1'b0;
    end else begin
      opAData <= opAD;
      opBData <= opBD;
      litOut <= litD;
      resultToWorkReg <= toWorkRegD;
      modeErr <= errD;
    end
  end

  assign stackPtr = sp;
  assign stackLimit = limitQ;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic isPush;
  logic isPop;
  logic limitLoaded;
  assign isPush = opValid && opClass == agu_pkg::CL_STACK && stackOp != agu_pkg::S_POP;
  assign isPop = opValid && opClass == agu_pkg::CL_STACK && stackOp == agu_pkg::S_POP;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      limitLoaded <= 1'b0;
    end else if (limWrEn) begin
      limitLoaded <= 1'b1;
    end
  end

  a_push_post_incr: assert property ( // R2
    isPush |=> ea == $past(sp) && sp == $past(sp) + agu_pkg::WORD_STEP)
    else $error("push did not write at pointer then increment");
  a_pop_pre_decr: assert property ( // R2
    isPop |=> ea == $past(sp) - agu_pkg::WORD_STEP && sp == ea && eaValid)
    else $error("pop did not decrement before reading");
  a_call_msb_clear: assert property ( // R3
    opValid && opClass == agu_pkg::CL_STACK && stackOp == agu_pkg::S_PUSH_CALL_HI
    |=> memWrData[15:8] == 8'h00)
    else $error("call push upper byte not clear");
  a_exc_status_byte: assert property ( // R4
    opValid && opClass == agu_pkg::CL_STACK && stackOp == agu_pkg::S_PUSH_EXC_HI
    |=> memWrData == {$past(statusLowByte), $past(pushData[7:0])})
    else $error("exception push lacks status low byte");
  a_limit_aligned: assert property ( // R5
    limitLoaded |-> stackLimit[0] == 1'b0)
    else $error("stack limit bit 0 not zero");
  a_limit_no_trap: assert property ( // R6
    limitLoaded && isPush && sp == limitQ && sp >= agu_pkg::SFR_FLOOR |=> !stackTrap)
    else $error("push at limit raised a trap");
  a_limit_next_trap: assert property ( // R6
    limitLoaded && isPush && sp == limitQ && !limWrEn ##1
    (isPush or (!opValid && !regWrEn && !limWrEn ##1 isPush)) |=> stackTrap)
    else $error("push beyond limit gave no trap");
  a_underflow_trap: assert property ( // R7
    isPop && sp < agu_pkg::SFR_FLOOR + agu_pkg::WORD_STEP |=> stackTrap && eaValid)
    else $error("underflow gave no trap");
  a_boot_guard: assert property ( // R9
    opValid && opClass == agu_pkg::CL_STACK && stackOp == agu_pkg::S_PUSH && bootProtEn &&
    !execInBoot && inWin(sp, agu_pkg::BOOT_RAM_LO, agu_pkg::BOOT_RAM_HI)
    |=> accessDenied && !memWrEn)
    else $error("boot secure RAM reached from outside boot code");
  a_file_addr: assert property ( // R11
    opValid && opClass == agu_pkg::CL_FILE |=> ea == {3'h0, $past(litField[12:0])} && memRdEn
    || accessDenied)
    else $error("file register address wrong");
  a_intdis_field: assert property ( // R22
    opValid && opClass == agu_pkg::CL_INTDIS |=> litOut[15:14] == 2'h0)
    else $error("interrupt disable literal wider than 14 bits");

  c_push_pop: cover property (isPush ##1 isPop);
  c_overflow: cover property (isPush ##1 stackTrap);
  c_dsp_dual: cover property (opValid && opClass == agu_pkg::CL_DSP ##1 yEaValid && !modeErr);
  c_denied: cover property (accessDenied);

endmodule

// file: testbench/data_mem_model.sv
// Data memory standing behind the address unit, keeps every word written
`timescale 1ns/1ns
module data_mem_model (
  // Clock
  input wire logic mclk,
  // Strobes and address from the address unit
  input wire logic memWrEn,
  input wire logic memRdEn,
  input wire logic [15:0] ea,
  input wire logic [15:0] memWrData,
  // Read return, unused by the unit
  output logic [15:0] rdData
);
  logic [15:0] store [logic [15:0]];

  initial rdData = 16'h0000;

  // ==========================================================================
  // Strobes stand one cycle, so the address is taken at the edge that ends it
  always @(posedge mclk) begin
    if (memWrEn) begin
      store[ea] = memWrData;
    end
    // Outside a read of a written word the bus toggles so a stale word is never mistaken for data
    if (memRdEn && store.exists(ea)) begin
      rdData <= store[ea];
    end else begin
      rdData <= ~rdData;
    end
  end

  function automatic logic [15:0] peek(input logic [15:0] addr);
    return store.exists(addr) ? store[addr] : 16'hXXXX;
  endfunction
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the address generation and stack check unit
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'b0, sys_rst = 1'b1, opValid = 1'b0, fileToWorkReg = 1'b0, ySel = 1'b0;
  agu_pkg::class_t opClass = agu_pkg::CL_FILE;
  agu_pkg::mode_t opMode = agu_pkg::M_DIRECT, yMode = agu_pkg::M_IND;
  agu_pkg::stk_t stackOp = agu_pkg::S_PUSH;
  logic [3:0] baseSel = 4'h0, offsetSel = 4'h3, regWrSel = 4'h0;
  logic [15:0] modConst = 16'h0000, litField = 16'h0000, yModConst = 16'h0000;
  logic [15:0] pushData = 16'h0000, regWrData = 16'h0000, limWrData = 16'h0000;
  logic [7:0] statusLowByte = 8'h00;
  logic regWrEn = 1'b0, limWrEn = 1'b0, bootProtEn = 1'b0, secProtEn = 1'b0;
  logic execInBoot = 1'b0, execInSecure = 1'b0;
  logic eaValid, yEaValid, memRdEn, memWrEn, resultToWorkReg, accessDenied, stackTrap, modeErr;
  logic [15:0] ea, yEa, memWrData, opAData, opBData, litOut, stackPtr, stackLimit, rdData;
  int badCount = 0, samplesChecked = 0, cycles = 0;

  addr_gen_stack_check dut (.mclk(mclk), .sys_rst(sys_rst), .opValid(opValid),
    .opClass(opClass), .opMode(opMode), .stackOp(stackOp), .baseSel(baseSel),
    .offsetSel(offsetSel), .modConst(modConst), .litField(litField),
    .fileToWorkReg(fileToWorkReg), .yMode(yMode), .ySel(ySel), .yModConst(yModConst),
    .pushData(pushData), .statusLowByte(statusLowByte), .regWrEn(regWrEn),
    .regWrSel(regWrSel), .regWrData(regWrData), .limWrEn(limWrEn), .limWrData(limWrData),
    .bootProtEn(bootProtEn), .secProtEn(secProtEn), .execInBoot(execInBoot),
    .execInSecure(execInSecure), .eaValid(eaValid), .ea(ea), .yEaValid(yEaValid),
    .yEa(yEa), .memRdEn(memRdEn), .memWrEn(memWrEn), .memWrData(memWrData),
    .opAData(opAData), .opBData(opBData), .litOut(litOut), .resultToWorkReg(resultToWorkReg),
    .accessDenied(accessDenied), .stackTrap(stackTrap), .modeErr(modeErr),
    .stackPtr(stackPtr), .stackLimit(stackLimit));

  data_mem_model mem (.mclk(mclk), .memWrEn(memWrEn), .memRdEn(memRdEn), .ea(ea),
    .memWrData(memWrData), .rdData(rdData));

  initial begin
    forever #4 mclk = ~mclk;
  end

  // ==========================================================================
  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      badCount++;
      wrap_up();
    end
  end

  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      badCount++;
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    samplesChecked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
      badCount++;
    end
  endtask

  // One request; outputs are sampled just after the edge that takes it
  task automatic op(input agu_pkg::class_t c, input agu_pkg::mode_t m,
                    input agu_pkg::stk_t s, input logic [3:0] b,
                    input logic [15:0] mc, input logic [15:0] lit);
    @(posedge mclk);
    opValid <= 1'b1;
    opClass <= c;
    opMode <= m;
    stackOp <= s;
    baseSel <= b;
    modConst <= mc;
    litField <= lit;
    pushData <= lit;
    @(posedge mclk);
    opValid <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic lim, input logic [3:0] sel, input logic [15:0] d);
    @(posedge mclk);
    regWrEn <= !lim;
    limWrEn <= lim;
    regWrSel <= sel;
    regWrData <= d;
    limWrData <= d;
    @(posedge mclk);
    regWrEn <= 1'b0;
    limWrEn <= 1'b0;
  endtask

  task automatic push(input agu_pkg::stk_t s, input logic [15:0] d);
    op(agu_pkg::CL_STACK, agu_pkg::M_IND, s, 4'hF, 16'h0000, d);
  endtask

  task automatic t_stack;
    chk16("sp after reset", agu_pkg::STACK_PTR_RST, stackPtr);
    wr(1'b1, 4'h0, 16'h0805);
    @(posedge mclk);
    chk16("limit bit0", 16'h0804, stackLimit);
    wr(1'b1, 4'h0, 16'hFFFF);
    @(posedge mclk);
    push(agu_pkg::S_PUSH, 16'hC3A5);
    chk16("push ea", 16'h0800, ea);
    chk1("push strobe", 1'b1, memWrEn);
    chk16("push sp", 16'h0802, stackPtr);
    op(agu_pkg::CL_STACK, agu_pkg::M_IND, agu_pkg::S_POP, 4'hF, 16'h0000, 16'h0000);
    chk16("pop ea", 16'h0800, ea);
    chk1("pop strobe", 1'b1, memRdEn);
    chk16("pop sp", 16'h0800, stackPtr);
    chk16("stored word", 16'hC3A5, mem.peek(16'h0800));
    // Memory answers at the edge that ends the read strobe
    @(posedge mclk);
    #1;
    chk16("popped word", 16'hC3A5, rdData);
    push(agu_pkg::S_PUSH, 16'h1234);
    push(agu_pkg::S_PUSH_CALL_HI, 16'hAB55);
    chk16("call upper word", 16'h0055, memWrData);
    @(posedge mclk) statusLowByte <= 8'h3C;
    push(agu_pkg::S_PUSH, 16'h5678);
    push(agu_pkg::S_PUSH_EXC_HI, 16'hAB12);
    chk16("exception upper word", 16'h3C12, memWrData);
    // The word lands in memory at the edge that ends the write strobe
    @(posedge mclk);
    #1;
    chk16("stacked exception word", 16'h3C12, mem.peek(16'h0806));
    repeat (4) op(agu_pkg::CL_STACK, agu_pkg::M_IND, agu_pkg::S_POP, 4'hF, 16'h0, 16'h0);
    chk1("no trap in range", 1'b0, stackTrap);
    op(agu_pkg::CL_STACK, agu_pkg::M_IND, agu_pkg::S_POP, 4'hF, 16'h0000, 16'h0000);
    chk1("underflow trap", 1'b1, stackTrap);
    chk16("underflow ea", 16'h07FE, ea);
    push(agu_pkg::S_PUSH, 16'h0001);
    chk1("low push trap", 1'b1, stackTrap);
    wr(1'b1, 4'h0, 16'h0802);
    @(posedge mclk);
    for (int k = 0; k < 3; k++) begin
      push(agu_pkg::S_PUSH, 16'h0100);
      chk1("limit trap", k == 2, stackTrap);
      chk1("trap with address", 1'b1, eaValid);
    end
    $display("stack test done");
  endtask

  task automatic t_modes;
    wr(1'b0, 4'h0, 16'h5A5A);
    wr(1'b0, 4'h1, 16'h1000);
    wr(1'b0, 4'h3, 16'h1234);
    @(posedge mclk) fileToWorkReg <= 1'b1;
    op(agu_pkg::CL_FILE, agu_pkg::M_DIRECT, agu_pkg::S_PUSH, 4'h0, 16'h0, 16'hFFFF);
    chk16("file address", 16'h1FFF, ea);
    chk1("file to work reg", 1'b1, resultToWorkReg);
    chk16("file work reg operand", 16'h5A5A, opAData);
    op(agu_pkg::CL_MCU, agu_pkg::M_DIRECT, agu_pkg::S_PUSH, 4'h1, 16'h0, 16'h0);
    chk16("mcu operand 1", 16'h1234, opAData);
    op(agu_pkg::CL_MCU, agu_pkg::M_LIT5, agu_pkg::S_PUSH, 4'h1, 16'h0, 16'h00FF);
    chk16("mcu lit5", 16'h001F, opBData);
    op(agu_pkg::CL_MCU, agu_pkg::M_INDEXED, agu_pkg::S_PUSH, 4'h1, 16'h0, 16'h0);
    chk1("mcu indexed refused", 1'b1, modeErr);
    op(agu_pkg::CL_MOVE, agu_pkg::M_IND, agu_pkg::S_PUSH, 4'h1, 16'h0, 16'h0);
    chk16("indirect ea", 16'h1000, ea);
    op(agu_pkg::CL_MOVE, agu_pkg::M_POST, agu_pkg::S_PUSH, 4'h1, 16'h0002, 16'h0);
    chk16("post ea", 16'h1000, ea);
    op(agu_pkg::CL_MOVE, agu_pkg::M_IND, agu_pkg::S_PUSH, 4'h1, 16'h0, 16'h0);
    chk16("after post", 16'h1002, ea);
    op(agu_pkg::CL_MOVE, agu_pkg::M_PRE, agu_pkg::S_PUSH, 4'h1, 16'hFFFE, 16'h0);
    chk16("pre ea", 16'h1000, ea);
    op(agu_pkg::CL_MOVE, agu_pkg::M_INDEXED, agu_pkg::S_PUSH, 4'h1, 16'h0, 16'h0);
    chk16("indexed ea", 16'h2234, ea);
    op(agu_pkg::CL_MOVE, agu_pkg::M_LITOFF, agu_pkg::S_PUSH, 4'h1, 16'h0, 16'h0010);
    chk16("lit offset ea", 16'h1010, ea);
    op(agu_pkg::CL_MOVE, agu_pkg::M_LIT8, agu_pkg::S_PUSH, 4'h1, 16'h0, 16'h01FF);
    chk16("lit8 operand", 16'h00FF, opBData);
    op(agu_pkg::CL_MOVE, agu_pkg::M_LIT16, agu_pkg::S_PUSH, 4'h1, 16'h0, 16'hBEEF);
    chk16("lit16 operand", 16'hBEEF, opBData);
    op(agu_pkg::CL_BRANCH, agu_pkg::M_LIT16, agu_pkg::S_PUSH, 4'h0, 16'h0, 16'h8001);
    chk16("branch literal", 16'h8001, litOut);
    op(agu_pkg::CL_INTDIS, agu_pkg::M_LIT16, agu_pkg::S_PUSH, 4'h0, 16'h0, 16'hFFFF);
    chk16("disable literal", 16'h3FFF, litOut);
    $display("mode test done");
  endtask

  task automatic t_dsp;
    logic [15:0] e;
    e = 16'h1200;
    for (int i = 0; i < 4; i++) wr(1'b0, 4'h8 + 4'(i), 16'h1100 + 16'(i) * 16'h0100);
    @(posedge mclk) yMode <= agu_pkg::M_POST;
    yModConst <= 16'h0004;
    for (int k = 1; k < 4; k++) begin
      op(agu_pkg::CL_DSP, agu_pkg::M_POST, agu_pkg::S_PUSH, 4'h1, 16'(2 * k), 16'h0);
      chk16("x prefetch ea", e, ea);
      chk16("y prefetch ea", 16'h1300 + 16'(4 * (k - 1)), yEa);
      chk1("y valid", 1'b1, yEaValid);
      e = e + 16'(2 * k);
    end
    @(posedge mclk) ySel <= 1'b1;
    @(posedge mclk) yMode <= agu_pkg::M_INDEXED;
    op(agu_pkg::CL_DSP, agu_pkg::M_IND, agu_pkg::S_PUSH, 4'h1, 16'h0, 16'h0);
    chk16("y indexed ea", 16'h2634, yEa);
    chk1("second pointer indexed ok", 1'b0, modeErr);
    op(agu_pkg::CL_DSP, agu_pkg::M_INDEXED, agu_pkg::S_PUSH, 4'h0, 16'h0, 16'h0);
    chk1("first pointer indexed refused", 1'b1, modeErr);
    $display("dsp test done");
  endtask

  task automatic t_secure;
    wr(1'b0, 4'h1, 16'h0810);
    wr(1'b0, 4'h2, 16'h0910);
    @(posedge mclk) bootProtEn <= 1'b1;
    @(posedge mclk) secProtEn <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      @(posedge mclk) execInBoot <= (g == 1);
      @(posedge mclk) execInSecure <= (g == 3);
      op(agu_pkg::CL_MOVE, agu_pkg::M_IND, agu_pkg::S_PUSH, g < 2 ? 4'h1 : 4'h2, 16'h0, 16'h0);
      chk1("segment gate", g == 0 || g == 2, accessDenied);
      chk1("read strobe", g == 1 || g == 3, memRdEn);
    end
    // Stack pointer still sits in the boot window and boot code is not running
    push(agu_pkg::S_PUSH, 16'h0BAD);
    chk1("boot push denied", 1'b1, accessDenied);
    chk1("boot push strobe", 1'b0, memWrEn);
    $display("secure test done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk1("no trap after reset", 1'b0, stackTrap);
    t_stack();
    t_modes();
    t_dsp();
    t_secure();
    wrap_up();
  end
endmodule
